// File: include/gpio_mux_pkg.sv
// Purpose: Shared constants for the pin mux and general-purpose port block
// Assumes: Register indices are word indices; byte address is four times
// Notes:   All implemented bits reset to zero
package gpio_mux_pkg;
    // ==========================================================
    // Register map
    localparam int ADDR_W = 18;
    localparam int IDX_W = 16;
    localparam logic [15:0] IDX_MUX_A = 16'h7090;
    localparam logic [15:0] IDX_MUX_B = 16'h7092;
    localparam logic [15:0] IDX_PORT_A = 16'h7098;
    localparam logic [15:0] IDX_PORT_B = 16'h709A;
    localparam logic [15:0] IDX_PORT_C = 16'h709C;
    localparam logic [15:0] IDX_PORT_D = 16'h709E;
    localparam logic [15:0] IDX_WIN_LO = 16'h7090;
    localparam logic [15:0] IDX_WIN_HI = 16'h709F;
    localparam int IDX_LSB = 2;
    localparam int PSEL_LSB = 1;
    localparam int PSEL_HI = 2;
    localparam int PGRP_LSB = 3;
    // ==========================================================
    // Fields
    localparam int PORT_N = 4;
    localparam int PIN_N = 8;
    localparam int PIN_ALL = 32;
    localparam int DIR_LSB = 8;
    localparam int DIR_MSB = 15;
    localparam int DAT_MSB = 7;
    localparam int LANE_HI = 1;
    localparam logic [15:0] RST_VAL = 16'h0000;
    localparam logic [15:0] MASK_ALL = 16'hFFFF;
    localparam logic [15:0] MUX_B_MASK_FULL = 16'h03FF;
    localparam logic [15:0] MUX_B_MASK_RED = 16'h0303;
    localparam logic [15:0] PORT_D_MASK_RED = 16'h0303;
    localparam int FLAG_BIT = 0;
    localparam int BTEST_BIT = 1;
    localparam int SER_LO = 2;
    localparam int SER_HI = 7;
    localparam int CLKO_BIT = 8;
    localparam int IRQ2_BIT = 9;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam logic [7:0] D_LOW_PINS = 8'h03;
    typedef logic [15:0] reg_word_type;
endpackage

// File: include/port_slice_if.sv
// Purpose: Bundle between the register core and one eight-pin port slice
// Assumes: One clock domain
// Notes:   Core drives controls, slice drives registered pin signals
`timescale 1ns/100ps
interface port_slice_if;
    logic [7:0] dir;
    logic [7:0] dat;
    logic [7:0] sel;
    logic [7:0] bond;
    logic [7:0] fn_out;
    logic [7:0] fn_oe;
    logic [7:0] pin_lvl;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] fn_in;
    modport core (output dir, dat, sel, bond, fn_out, fn_oe, pin_lvl,
                  input pin_out, pin_oe, fn_in);
    modport slice (input dir, dat, sel, bond, fn_out, fn_oe, pin_lvl,
                   output pin_out, pin_oe, fn_in);
endinterface // port_slice_if

// File: src/bit_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 32
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [W-1:0] d, // Raw pin levels
    output logic [W-1:0] q // Synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // bit_sync

// File: src/port_slice.sv
// Purpose: Pin driver for one eight-pin port
// Assumes: Controls arrive from the register core on the same clock
// Notes:   Every output is a flop, so peripherals see one cycle of delay
`timescale 1ns/100ps
module port_slice (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Async reset, active high
    port_slice_if.slice ps // Controls and pin signals
);
    logic [7:0] out_nxt;
    logic [7:0] oe_nxt;
    logic [7:0] in_nxt;

    // Peripheral or port register owns the driver; unbonded pins never drive but still feed fn_in
    assign out_nxt = ps.bond & ((ps.sel & ps.fn_out) | (~ps.sel & ps.dat));
    assign oe_nxt = ps.bond & ((ps.sel & ps.fn_oe) | (~ps.sel & ps.dir));
    assign in_nxt = ps.sel & ps.pin_lvl;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ps.pin_out <= '0;
            ps.pin_oe <= '0;
            ps.fn_in <= '0;
        end
        else
        begin
            ps.pin_out <= out_nxt;
            ps.pin_oe <= oe_nxt;
            ps.fn_in <= in_nxt;
        end
    end
endmodule // port_slice

// File: src/gpio_mux.sv
// Purpose: Pin multiplexer and four eight-bit general-purpose ports
// Assumes: APB slave on ref_clk; pins asynchronous
// Notes:   Pin bit 8*p+i is port p pin i; FULL selects the larger layout
//
// How it works
// - mux A bit one selects peripheral function
// - mux A bits 0-7 route port A
// - mux A bits 8-15 route port B
// - mux B 0,1,8 set select port pins
// - mux B bit 9 set selects interrupt two
// - reduced layout: mux B 2-7 reserved
// - direction bits 15-8 make pins outputs
// - input pin data bit reads pin level
// - output pin driven from written data
// - reset clears every implemented bit
// - reduced port D has bits 9-8, 1-0
// - unbonded port D bits stay plain storage in the full layout
// - port registers at consecutive even indices
// - variant fixes mux B and D layout
// - data bits read synced pin on bonded pins, stored data on unbonded
// - window 7090h-709Fh, mux A at base
`timescale 1ns/100ps
module gpio_mux #(
    parameter bit FULL = 1'b1, // Larger layout with serial and fieldbus
    parameter bit D_BONDED = 1'b1 // Port D pins 7-2 reach the board
) (
    input wire logic ref_clk, // System clock, 250 MHz
    input wire logic rst, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [gpio_mux_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, outside window
    input wire logic [31:0] pin_in, // Board pin levels
    output logic [31:0] pin_out, // Board pin drive value
    output logic [31:0] pin_oe, // Board pin drive enable
    input wire logic [31:0] fn_out, // Peripheral output values
    input wire logic [31:0] fn_oe, // Peripheral output enables
    output logic [31:0] fn_in // Pin levels to routed peripherals
);
    // ==========================================================
    // Register state
    logic [15:0] mux_a_r;
    logic [15:0] mux_b_r;
    logic [15:0] port_r [gpio_mux_pkg::PORT_N];
    logic [31:0] pin_s;
    logic [31:0] sel;
    logic [31:0] bond;
    logic [31:0] pin_rd;
    logic [15:0] mux_b_mask;
    logic [15:0] port_d_mask;
    logic [15:0] idx;
    logic [15:0] lanes;
    logic [15:0] rd_word;
    logic [15:0] port_rd;
    logic [1:0] psel_idx;
    logic setup;
    logic access;
    logic in_win;
    logic hit_a;
    logic hit_b;
    logic hit_port;

    bit_sync #(.W(gpio_mux_pkg::PIN_ALL)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(pin_in),
        .q(pin_s)
    );

    // ==========================================================
    // Helpers
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] wd, input logic [15:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    function automatic logic [15:0] port_mask(input int p);
        if (p == gpio_mux_pkg::PORT_D && !FULL)
            port_mask = gpio_mux_pkg::PORT_D_MASK_RED;
        else
            port_mask = gpio_mux_pkg::MASK_ALL;
    endfunction

    // ==========================================================
    // Variant layout
    // fixed per variant
    assign mux_b_mask = FULL ? gpio_mux_pkg::MUX_B_MASK_FULL
                             : gpio_mux_pkg::MUX_B_MASK_RED;
    assign port_d_mask = port_mask(gpio_mux_pkg::PORT_D);

    // ==========================================================
    // Pin routing, one means peripheral
    // mux A one selects peripheral
    assign sel[15:0] = mux_a_r;
    assign sel[16 + gpio_mux_pkg::FLAG_BIT] =
        ~mux_b_r[gpio_mux_pkg::FLAG_BIT];
    assign sel[16 + gpio_mux_pkg::BTEST_BIT] =
        ~mux_b_r[gpio_mux_pkg::BTEST_BIT];
    assign sel[16 + gpio_mux_pkg::SER_HI:16 + gpio_mux_pkg::SER_LO] =
        mux_b_r[gpio_mux_pkg::SER_HI:gpio_mux_pkg::SER_LO];
    assign sel[24] = ~mux_b_r[gpio_mux_pkg::CLKO_BIT];
    assign sel[25] = mux_b_r[gpio_mux_pkg::IRQ2_BIT];
    assign sel[31:26] = '0;

    assign bond[23:0] = '1;
    assign bond[31:24] = D_BONDED ? 8'hFF : gpio_mux_pkg::D_LOW_PINS;

    // ==========================================================
    // Port slices
    genvar g;
    generate
        for (g = 0; g < gpio_mux_pkg::PORT_N; g++)
        begin : g_port
            port_slice_if ps ();
            assign ps.dir = port_r[g][gpio_mux_pkg::DIR_MSB:
                                      gpio_mux_pkg::DIR_LSB];
            assign ps.dat = port_r[g][gpio_mux_pkg::DAT_MSB:0];
            assign ps.sel = sel[g*8 +: 8];
            assign ps.bond = bond[g*8 +: 8];
            assign ps.fn_out = fn_out[g*8 +: 8];
            assign ps.fn_oe = fn_oe[g*8 +: 8];
            assign ps.pin_lvl = pin_s[g*8 +: 8];
            assign pin_out[g*8 +: 8] = ps.pin_out;
            assign pin_oe[g*8 +: 8] = ps.pin_oe;
            assign fn_in[g*8 +: 8] = ps.fn_in;
            assign pin_rd[g*8 +: 8] = (bond[g*8 +: 8] & pin_s[g*8 +: 8])
                | (~bond[g*8 +: 8] & port_r[g][gpio_mux_pkg::DAT_MSB:0]);
            port_slice u_slice (
                .ref_clk(ref_clk),
                .rst(rst),
                .ps(ps.slice)
            );
        end
    endgenerate

    // ==========================================================
    // APB decode
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign idx = paddr[gpio_mux_pkg::ADDR_W-1:gpio_mux_pkg::IDX_LSB];
    assign in_win = (idx >= gpio_mux_pkg::IDX_WIN_LO)
                 && (idx <= gpio_mux_pkg::IDX_WIN_HI);
    assign hit_a = idx == gpio_mux_pkg::IDX_MUX_A;
    assign hit_b = idx == gpio_mux_pkg::IDX_MUX_B;
    assign hit_port = (idx[15:gpio_mux_pkg::PGRP_LSB]
                       == gpio_mux_pkg::IDX_PORT_A[15:gpio_mux_pkg::PGRP_LSB])
                   && !idx[0];
    assign psel_idx = idx[gpio_mux_pkg::PSEL_HI:gpio_mux_pkg::PSEL_LSB];
    assign lanes = {{8{pstrb[gpio_mux_pkg::LANE_HI]}}, {8{pstrb[0]}}};

    assign port_rd = {port_r[psel_idx][gpio_mux_pkg::DIR_MSB:
                                       gpio_mux_pkg::DIR_LSB],
                      pin_rd[{psel_idx, 3'h0} +: 8]};
    assign rd_word = hit_a ? mux_a_r
                   : hit_b ? mux_b_r
                   : hit_port ? port_rd
                   : gpio_mux_pkg::RST_VAL;

    // ==========================================================
    // APB answer: one access cycle, no wait states
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~in_win;
            prdata <= (setup & ~pwrite) ? {16'h0000, rd_word} : '0;
        end
    end

    // ==========================================================
    // Register writes
    // everything resets to zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            mux_a_r <= gpio_mux_pkg::RST_VAL;
            mux_b_r <= gpio_mux_pkg::RST_VAL;
            for (int p = 0; p < gpio_mux_pkg::PORT_N; p++)
                port_r[p] <= gpio_mux_pkg::RST_VAL;
        end
        else if (access & pwrite)
        begin
            if (hit_a)
                mux_a_r <= merge(mux_a_r, pwdata[15:0], lanes);
            if (hit_b)
                mux_b_r <= merge(mux_b_r, pwdata[15:0], lanes & mux_b_mask);
            for (int p = 0; p < gpio_mux_pkg::PORT_N; p++)
                if (hit_port && psel_idx == 2'(p))
                    port_r[p] <= merge(port_r[p], pwdata[15:0],
                                       lanes & port_mask(p));
        end
    end

    // ==========================================================
    // Checks
    rst_clear_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst) |-> mux_a_r == '0 && mux_b_r == '0 && port_r[0] == '0)
    else $error("register not cleared by reset");

    reserved_zero_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        (mux_b_r & ~mux_b_mask) == '0 && (port_r[3] & ~port_d_mask) == '0)
    else $error("reserved bit holds a one");

    apb_answer_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

    win_error_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        setup && !in_win |=> pslverr && prdata == '0)
    else $error("outside window not flagged");

    port_write_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        access && pwrite && idx == gpio_mux_pkg::IDX_PORT_B
        && pstrb[1:0] == 2'h3 |=> port_r[1] == $past(pwdata[15:0]))
    else $error("port B write lost");

    sync_delay_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) |-> pin_s == $past(pin_in, 2))
    else $error("pin sync delay wrong");

    pin_read_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        setup && !pwrite && idx == gpio_mux_pkg::IDX_PORT_A
        |=> prdata[7:0] == $past(pin_s[7:0]))
    else $error("port A read does not show pin");

    periph_route_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        $past(mux_a_r[0]) && !$past(rst)
        |-> pin_out[0] == $past(fn_out[0]) && pin_oe[0] == $past(fn_oe[0]))
    else $error("peripheral not routed to pin A0");

    gpio_drive_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        !$past(mux_a_r[8]) && !$past(rst)
        |-> pin_oe[8] == $past(port_r[1][8]) && pin_out[8] == $past(port_r[1][0]))
    else $error("port B pin 0 not driven from register");

    clk_out_a:
    assert property (@(posedge ref_clk) disable iff (rst)
        !$past(mux_b_r[8]) && !$past(rst) |-> pin_out[24] == $past(fn_out[24]))
    else $error("clock output not routed to port D pin 0");
endmodule // gpio_mux

// File: testbench/pad_board_model.sv
// Purpose: Board pads seen by the pin mux block
// Assumes: Each pad has a pull resistor whose level the bench sets
// Notes:   A pad that no one drives settles to its pull level
`timescale 1ns/100ps
module pad_board_model (
    input wire logic [31:0] pin_out, // Design drive value
    input wire logic [31:0] pin_oe, // Design drive enable
    input wire logic [31:0] pull, // Pull level of each pad
    output logic [31:0] pin_in // Resolved pad level
);
    // ==========================================================
    // Pad resolution
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
endmodule // pad_board_model

// File: testbench/test_pin_mux_and_gpio_ports.sv
// Purpose: Self-checking bench for the pin mux and port block
// Assumes: One full, bonded instance and one reduced, unbonded one
// Notes:   Data bits read synced pads, so reads wait for the sync flops
`timescale 1ns/100ps
module test_pin_mux_and_gpio_ports;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sel2 = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] pull = 32'h9C365AE1;
    logic [31:0] fn_out = 32'h6B2DC94E;
    logic [31:0] fn_oe = 32'hF0F03C3C;
    logic [31:0] rd1, rd2, out1, out2, oe1, oe2, in1, in2, fi1, fi2;
    logic rdy1, rdy2, er1, er2;
    logic [31:0] rt, gd, gv, eoe, lvl;
    logic [15:0] ma, mb;
    logic [7:0] dir [4];
    logic [7:0] dat [4];
    logic [15:0] ridx [6] = '{gpio_mux_pkg::IDX_MUX_A,
        gpio_mux_pkg::IDX_MUX_B, gpio_mux_pkg::IDX_PORT_A,
        gpio_mux_pkg::IDX_PORT_B, gpio_mux_pkg::IDX_PORT_C,
        gpio_mux_pkg::IDX_PORT_D};
    logic [15:0] hole [6] = '{16'h7091, 16'h7094, 16'h7097, 16'h709F,
        16'h70A0, 16'h708F};
    logic [15:0] cfg_a [3] = '{16'h0000, 16'hFFFF, 16'h5AC3};
    logic [15:0] cfg_b [3] = '{16'h0303, 16'h00FC, 16'h0201};
    int err_total = 0;
    int checked = 0;

    always #2 ref_clk = ~ref_clk;

    gpio_mux #(.FULL(1'b1), .D_BONDED(1'b1)) u_dut (.ref_clk(ref_clk),
        .rst(rst), .psel(psel & ~sel2), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(rd1),
        .pready(rdy1), .pslverr(er1), .pin_in(in1), .pin_out(out1),
        .pin_oe(oe1), .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fi1));
    gpio_mux #(.FULL(1'b0), .D_BONDED(1'b0)) u_red (.ref_clk(ref_clk),
        .rst(rst), .psel(psel & sel2), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(rd2),
        .pready(rdy2), .pslverr(er2), .pin_in(in2), .pin_out(out2),
        .pin_oe(oe2), .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fi2));
    pad_board_model u_pad1 (.pin_out(out1), .pin_oe(oe1), .pull(pull),
        .pin_in(in1));
    pad_board_model u_pad2 (.pin_out(out2), .pin_oe(oe2), .pull(pull),
        .pin_in(in2));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // Request held until pready is sampled high; release left to settle,
    // which drops select and enable
    task automatic apb(input logic w, input logic [15:0] idx,
        input logic [15:0] wd, input logic [31:0] exp, input logic xe);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while ((sel2 ? rdy2 : rdy1) !== 1'b1);
        if (!w)
            chk(sel2 ? rd2 : rd1, exp);
        chk({31'h0, sel2 ? er2 : er1}, {31'h0, xe});
    endtask

    // Idle long enough for drive plus two sync stages
    task automatic settle();
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic report_and_stop();
        $display("counts: %0d checked, %0d mismatched", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end

    // ==========================================================
    // Tests
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        chk(oe1, fn_oe & 32'h01030000);
        for (int i = 0; i < 6; i++)
            apb(1'b0, ridx[i], 16'h0, i < 2 ? 32'h0 :
                {24'h0, pull[8*(i-2) +: 8]}, 1'b0);
        settle();
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, hole[i], 16'hFFFF, 32'h0, i > 3);
            apb(1'b0, hole[i], 16'h0, 32'h0, i > 3);
        end
        apb(1'b1, ridx[0], 16'hFFFF, 32'h0, 1'b0);
        apb(1'b0, ridx[0], 16'h0, 32'h0000FFFF, 1'b0);
        pstrb <= 4'h2;
        apb(1'b1, ridx[0], 16'h1234, 32'h0, 1'b0);
        pstrb <= 4'hF;
        apb(1'b0, ridx[0], 16'h0, 32'h000012FF, 1'b0);
        apb(1'b1, ridx[1], 16'hFFFF, 32'h0, 1'b0);
        apb(1'b0, ridx[1], 16'h0, 32'h000003FF, 1'b0);
        settle();
        $display("test reserved done");
        for (int c = 0; c < 3; c++)
        begin
            ma = cfg_a[c];
            mb = cfg_b[c];
            pull <= pull ^ 32'h3C3CA5A5;
            fn_out <= fn_out ^ 32'h5A5A0FF0;
            apb(1'b1, ridx[0], ma, 32'h0, 1'b0);
            apb(1'b1, ridx[1], mb, 32'h0, 1'b0);
            for (int p = 0; p < 4; p++)
            begin
                dir[p] = 8'hC3 ^ 8'(p * 37 + c * 90);
                dat[p] = 8'hA5 ^ 8'(c * 51 + p);
                apb(1'b1, ridx[p+2], {dir[p], dat[p]}, 32'h0, 1'b0);
            end
            settle();
            rt = {6'h00, mb[9], ~mb[8], mb[7:2], ~mb[1:0], ma};
            gd = {dir[3], dir[2], dir[1], dir[0]};
            gv = {dat[3], dat[2], dat[1], dat[0]};
            eoe = (rt & fn_oe) | (~rt & gd);
            lvl = (eoe & ((rt & fn_out) | (~rt & gv))) | (~eoe & pull);
            chk(oe1, eoe);
            chk(out1 & eoe, lvl & eoe);
            chk(fi1, rt & lvl);
            apb(1'b0, ridx[0], 16'h0, {16'h0, ma}, 1'b0);
            apb(1'b0, ridx[1], 16'h0, {16'h0, mb}, 1'b0);
            for (int p = 0; p < 4; p++)
                apb(1'b0, ridx[p+2], 16'h0,
                    {16'h0, dir[p], lvl[8*p +: 8]}, 1'b0);
            settle();
        end
        $display("test routing done");
        sel2 <= 1'b1;
        @(posedge ref_clk);
        apb(1'b1, ridx[1], 16'hFFFF, 32'h0, 1'b0);
        apb(1'b1, ridx[5], 16'hFFFF, 32'h0, 1'b0);
        settle();
        apb(1'b0, ridx[1], 16'h0, 32'h00000303, 1'b0);
        apb(1'b0, ridx[5], 16'h0, {16'h0, 8'h03, 6'h00,
            fn_oe[25] ? fn_out[25] : pull[25], 1'b1}, 1'b0);
        chk({24'h0, oe2[31:24]}, {30'h0, fn_oe[25], 1'b1});
        chk({31'h0, out2[24]}, 32'h00000001);
        settle();
        sel2 <= 1'b0;
        $display("test reduced done");
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        chk(oe1, fn_oe & 32'h01030000);
        apb(1'b0, ridx[0], 16'h0, 32'h0, 1'b0);
        apb(1'b0, ridx[2], 16'h0, {24'h0, pull[7:0]}, 1'b0);
        settle();
        $display("test second reset done");
        report_and_stop();
    end
endmodule // test_pin_mux_and_gpio_ports
